// [hdl/tcsc_pkg.sv]
// Constants and types for trigger clock and sync reference configuration
package tcsc_pkg;

    // ------------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------------
    localparam logic [9:0] TCSC_OFS_DUAL_CLK = 10'h048;
    localparam logic [9:0] TCSC_OFS_TRIG_DIV = 10'h050;
    localparam logic [9:0] TCSC_OFS_TRIG_OUT = 10'h051;
    localparam logic [9:0] TCSC_OFS_SYNC_CTRL = 10'h080;
    localparam logic [9:0] TCSC_OFS_SAMPLED_IN = 10'h03c;

    // ------------------------------------------------------------------
    // Reset values and writable masks
    // ------------------------------------------------------------------
    localparam logic [7:0] TCSC_RST_DUAL_CLK = 8'h00;
    localparam logic [7:0] TCSC_RST_TRIG_DIV = 8'h00;
    localparam logic [7:0] TCSC_RST_TRIG_OUT = 8'h00;
    localparam logic [15:0] TCSC_RST_SYNC_CTRL = 16'h2000;
    localparam logic [15:0] TCSC_MASK_SYNC_CTRL = 16'he11f;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int TCSC_BIT_DUAL_SEL = 0;
    localparam int TCSC_BIT_PIN_DRIVE = 0;
    localparam int TCSC_DIV_MSB = 6;
    localparam int TCSC_BIT_PROC_EN = 15;
    localparam int TCSC_BIT_RECV_SLEEP = 13;
    localparam int TCSC_BIT_BANK_IN = 4;

    // ------------------------------------------------------------------
    // Divider constants
    // ------------------------------------------------------------------
    localparam int TCSC_PRE_DIV = 8;
    localparam int TCSC_HALF_W = 11;

    typedef enum logic [0:0] {
        TCSC_HOLD_FIRST = 1'b0,
        TCSC_HOLD_SECOND = 1'b1
    } tcsc_hold_t;

endpackage

// [hdl/tcsc_cfg_if.sv]
// Configuration and trigger carrier between the block's own modules
`timescale 1ns/1ps
interface tcsc_cfg_if;
    logic dual_sel;
    logic [6:0] div_val;
    logic run;
    logic dp_run;
    logic trig_level;
    logic trig_rise;

    modport ctl (output dual_sel, output div_val, output run, output dp_run,
                 input trig_level, input trig_rise);
    modport gen (input dual_sel, input div_val, input run,
                 output trig_level, output trig_rise);
    modport hold (input dual_sel, input dp_run);
endinterface

// [hdl/tcsc_trig_div.sv]
// Trigger clock divider running on the device clock
`timescale 1ns/1ps
module tcsc_trig_div
    import tcsc_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    // Configuration and trigger
    tcsc_cfg_if.gen cfg
);

    logic [TCSC_HALF_W-1:0] cnt_ff;
    logic [TCSC_HALF_W-1:0] nxt_cnt;
    logic level_ff;
    logic rise_ff;
    wire [TCSC_HALF_W-1:0] half_len;
    wire at_end;

    // ------------------------------------------------------------------
    // Half period = 4 * (1 + dual) * (1 + div) device clocks
    // ------------------------------------------------------------------
    assign half_len = TCSC_HALF_W'((TCSC_PRE_DIV / 2)
                      * (32'(cfg.dual_sel) + 32'd1)
                      * (32'(cfg.div_val) + 32'd1));
    assign at_end = (cnt_ff == TCSC_HALF_W'(1)) || (cnt_ff == '0);
    assign nxt_cnt = at_end ? half_len : cnt_ff - TCSC_HALF_W'(1);

    always_ff @(posedge clk)
    begin
        if (ce && (rst || !cfg.run))
        begin
            cnt_ff <= '0;
            level_ff <= 1'b0;
            rise_ff <= 1'b0;
        end
        else if (ce)
        begin
            cnt_ff <= nxt_cnt;
            level_ff <= at_end ? ~level_ff : level_ff;
            rise_ff <= at_end && !level_ff;
        end
    end

    assign cfg.trig_level = level_ff;
    assign cfg.trig_rise = rise_ff;

endmodule // tcsc_trig_div

// [hdl/tcsc_hold.sv]
// Sample hold stage for one or two converter clocks per sample
`timescale 1ns/1ps
module tcsc_hold
    import tcsc_pkg::*;
#(
    parameter int W = 12
)
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    // Mode
    tcsc_cfg_if.hold cfg,
    // Samples
    input wire logic [W-1:0] din,
    output logic [W-1:0] dout
);

    tcsc_hold_t phase_ff;
    logic [W-1:0] q_ff;
    wire load;

    // Two-clock hold takes a new sample only on the first phase
    assign load = !cfg.dual_sel || (phase_ff == TCSC_HOLD_FIRST);

    always_ff @(posedge clk)
    begin
        if (ce && (rst || !cfg.dp_run))
        begin
            phase_ff <= TCSC_HOLD_FIRST;
            q_ff <= '0;
        end
        else if (ce)
        begin
            phase_ff <= (cfg.dual_sel && phase_ff == TCSC_HOLD_FIRST)
                        ? TCSC_HOLD_SECOND : TCSC_HOLD_FIRST;
            q_ff <= load ? din : q_ff;
        end
    end

    assign dout = q_ff;

endmodule // tcsc_hold

// [hdl/tcsc_top.sv]
// Top of trigger clock, sample hold and sync reference configuration
//
// Implementation choice: strobed register access.
`timescale 1ns/1ps
// How it works
// - Dual select 0 holds each sample one clock, 1 holds it two clocks.
// - Trigger clock is device clock over 8, over 1+dual, over 1+divide.
// - Pin low when drive bit 0; else trigger clock while oscillator runs.
// - Processor enable passes sync edges to logic; clear blocks them.
// - Tone and bank select sampled on trigger rise; frozen when clock stops.
module tcsc_top
    import tcsc_pkg::*;
#(
    parameter int SAMPLE_W = 12,
    parameter int TONE_W = 4
)
(
    // Clock, reset, clock enable
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    // Register port
    input wire logic [9:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata,
    // Run controls from elsewhere in the device
    input wire logic datapath_run,
    input wire logic osc_run,
    // Sample path
    input wire logic [SAMPLE_W-1:0] sample_in,
    output logic [SAMPLE_W-1:0] sample_out,
    // Trigger clock pin
    output logic trig_clk_pin,
    // Tone select inputs and their sampled values
    input wire logic [TONE_W-1:0] tone_sel_in,
    input wire logic bank_sel_in,
    output logic [TONE_W-1:0] tone_sel_q,
    output logic bank_sel_q,
    // Sync reference
    input wire logic sync_ref_in,
    output logic sync_ref_edge,
    output logic sync_ref_receiver_sleep
);

    // ------------------------------------------------------------------
    // Configuration registers
    // ------------------------------------------------------------------
    logic [7:0] dual_clock_mode_select_ff;
    logic [7:0] trigger_clock_divider_ff;
    logic [7:0] trigger_output_control_ff;
    logic [15:0] sync_reference_control_ff;
    logic [15:0] rdata_ff;
    logic [TONE_W-1:0] tone_sel_q_ff;
    logic bank_sel_q_ff;

    wire rst_go;
    wire wr_go;
    wire wr_dual;
    wire wr_div;
    wire wr_out;
    wire wr_sync;
    wire hit_dual;
    wire hit_div;
    wire hit_out;
    wire hit_sync;
    wire hit_sampled;
    wire [15:0] sync_wr_val;
    wire [7:0] sampled_val;
    wire [15:0] rd_mux;

    assign hit_dual = (reg_addr == TCSC_OFS_DUAL_CLK);
    assign hit_div = (reg_addr == TCSC_OFS_TRIG_DIV);
    assign hit_out = (reg_addr == TCSC_OFS_TRIG_OUT);
    assign hit_sync = (reg_addr == TCSC_OFS_SYNC_CTRL);
    assign hit_sampled = (reg_addr == TCSC_OFS_SAMPLED_IN);

    // Reset also waits for the enable, so a frozen block stays frozen
    assign rst_go = ce && rst;
    assign wr_go = ce && reg_wr;

    assign wr_dual = wr_go && hit_dual;
    assign wr_div = wr_go && hit_div;
    assign wr_out = wr_go && hit_out;
    assign wr_sync = wr_go && hit_sync;

    // Read-only bits of the sync control word keep their value
    assign sync_wr_val = (reg_wdata & TCSC_MASK_SYNC_CTRL)
                         | (sync_reference_control_ff
                            & ~TCSC_MASK_SYNC_CTRL);

    always_ff @(posedge clk)
    begin
        if (rst_go)
        begin
            dual_clock_mode_select_ff <= TCSC_RST_DUAL_CLK;
        end
        else if (wr_dual)
        begin
            dual_clock_mode_select_ff <= reg_wdata[7:0];
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst_go)
        begin
            trigger_clock_divider_ff <= TCSC_RST_TRIG_DIV;
        end
        else if (wr_div)
        begin
            trigger_clock_divider_ff <= reg_wdata[7:0];
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst_go)
        begin
            trigger_output_control_ff <= TCSC_RST_TRIG_OUT;
        end
        else if (wr_out)
        begin
            trigger_output_control_ff <= reg_wdata[7:0];
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst_go)
        begin
            sync_reference_control_ff <= TCSC_RST_SYNC_CTRL;
        end
        else if (wr_sync)
        begin
            sync_reference_control_ff <= sync_wr_val;
        end
    end

    // ------------------------------------------------------------------
    // Read path, data valid only in the cycle after the strobe
    // ------------------------------------------------------------------
    assign sampled_val = {3'h0, bank_sel_q_ff, tone_sel_q_ff};

    assign rd_mux = hit_dual ? {8'h00, dual_clock_mode_select_ff}
                  : hit_div ? {8'h00, trigger_clock_divider_ff}
                  : hit_out ? {8'h00, trigger_output_control_ff}
                  : hit_sync ? sync_reference_control_ff
                  : hit_sampled ? {8'h00, sampled_val}
                  : 16'h0000;

    always_ff @(posedge clk)
    begin
        if (rst_go)
        begin
            rdata_ff <= 16'h0000;
        end
        else if (ce)
        begin
            rdata_ff <= reg_rd ? rd_mux : 16'h0000;
        end
    end

    assign reg_rdata = rdata_ff;

    // ------------------------------------------------------------------
    // Shared configuration to the divider and the hold stage
    // ------------------------------------------------------------------
    tcsc_cfg_if cfg_bus ();

    wire dual_sel;
    wire [6:0] trig_div_val;
    wire pin_drive;

    assign dual_sel = dual_clock_mode_select_ff[TCSC_BIT_DUAL_SEL];
    assign trig_div_val = trigger_clock_divider_ff[TCSC_DIV_MSB:0];
    assign pin_drive = trigger_output_control_ff[TCSC_BIT_PIN_DRIVE];

    // Config is taken live; the host only changes it while stopped
    assign cfg_bus.dual_sel = dual_sel;
    assign cfg_bus.div_val = trig_div_val;
    assign cfg_bus.run = osc_run;
    assign cfg_bus.dp_run = datapath_run;

    // ------------------------------------------------------------------
    // Trigger clock generation and sample hold
    // ------------------------------------------------------------------
    tcsc_trig_div u_trig_div (
        .clk (clk),
        .rst (rst),
        .ce (ce),
        .cfg (cfg_bus.gen)
    );

    tcsc_hold #(
        .W (SAMPLE_W)
    ) u_hold (
        .clk (clk),
        .rst (rst),
        .ce (ce),
        .cfg (cfg_bus.hold),
        .din (sample_in),
        .dout (sample_out)
    );

    // ------------------------------------------------------------------
    // Trigger pin drive
    // ------------------------------------------------------------------
    logic trig_pin_ff;
    wire nxt_trig_pin;

    assign nxt_trig_pin = pin_drive && osc_run && cfg_bus.trig_level;

    always_ff @(posedge clk)
    begin
        if (rst_go)
        begin
            trig_pin_ff <= 1'b0;
        end
        else if (ce)
        begin
            trig_pin_ff <= nxt_trig_pin;
        end
    end

    assign trig_clk_pin = trig_pin_ff;

    // ------------------------------------------------------------------
    // Tone and bank select sampling on trigger rise
    // ------------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (rst_go)
        begin
            tone_sel_q_ff <= '0;
            bank_sel_q_ff <= 1'b0;
        end
        else if (ce && cfg_bus.trig_rise)
        begin
            tone_sel_q_ff <= tone_sel_in;
            bank_sel_q_ff <= bank_sel_in;
        end
    end

    assign tone_sel_q = tone_sel_q_ff;
    assign bank_sel_q = bank_sel_q_ff;

    // ------------------------------------------------------------------
    // Sync reference edge gating
    // ------------------------------------------------------------------
    logic sync_prev_ff;
    logic sync_edge_ff;
    logic recv_sleep_ff;
    wire proc_en;
    wire nxt_sync_edge;

    assign proc_en = sync_reference_control_ff[TCSC_BIT_PROC_EN];
    // Receiver must already be awake when processing is enabled
    assign nxt_sync_edge = proc_en && sync_ref_in && !sync_prev_ff;

    always_ff @(posedge clk)
    begin
        if (rst_go)
        begin
            sync_prev_ff <= 1'b0;
        end
        else if (ce)
        begin
            sync_prev_ff <= sync_ref_in;
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst_go)
        begin
            sync_edge_ff <= 1'b0;
        end
        else if (ce)
        begin
            sync_edge_ff <= nxt_sync_edge;
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst_go)
        begin
            recv_sleep_ff <= TCSC_RST_SYNC_CTRL[TCSC_BIT_RECV_SLEEP];
        end
        else if (ce)
        begin
            recv_sleep_ff <= sync_reference_control_ff[TCSC_BIT_RECV_SLEEP];
        end
    end

    assign sync_ref_edge = sync_edge_ff;
    assign sync_ref_receiver_sleep = recv_sleep_ff;

endmodule // tcsc_top

// [testbench/tcsc_top_asserts.sv]
// Port checker for the trigger clock and sync configuration top
`timescale 1ns/1ps
module tcsc_top_asserts
    import tcsc_pkg::*;
#(
    parameter int SAMPLE_W = 12,
    parameter int TONE_W = 4
)
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    // Register port
    input wire logic [9:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [15:0] reg_rdata,
    // Device side
    input wire logic datapath_run,
    input wire logic osc_run,
    input wire logic [SAMPLE_W-1:0] sample_in,
    input wire logic [SAMPLE_W-1:0] sample_out,
    input wire logic trig_clk_pin,
    input wire logic [TONE_W-1:0] tone_sel_in,
    input wire logic bank_sel_in,
    input wire logic [TONE_W-1:0] tone_sel_q,
    input wire logic bank_sel_q,
    input wire logic sync_ref_in,
    input wire logic sync_ref_edge,
    input wire logic sync_ref_receiver_sleep
);
    // ----
    // Mirror of the control bits
    // ----
    logic dual_ff, drive_ff, proc_ff, sleep_ff;
    wire logic wr_go = ce && reg_wr && !rst;
    always_ff @(posedge clk)
        if (ce && rst)
            {dual_ff, drive_ff, proc_ff, sleep_ff} <= 4'h1;
        else if (wr_go && reg_addr == TCSC_OFS_DUAL_CLK)
            dual_ff <= reg_wdata[0];
        else if (wr_go && reg_addr == TCSC_OFS_TRIG_OUT)
            drive_ff <= reg_wdata[0];
        else if (wr_go && reg_addr == TCSC_OFS_SYNC_CTRL)
            {proc_ff, sleep_ff} <= {reg_wdata[15], reg_wdata[13]};
    // ----
    // Properties
    // ----
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);
    sync_mask_a: assert property ($past(ce && reg_rd &&
        reg_addr == TCSC_OFS_SYNC_CTRL) |-> (reg_rdata & 16'h1ee0) == 16'h0)
        else $error("reserved sync control bits read non zero");
    osc_off_low_a: assert property (ce && !osc_run |=> !trig_clk_pin)
        else $error("trigger pin high while oscillator stopped");
    drive_off_a: assert property (ce && !drive_ff && !$past(drive_ff)
        |=> !trig_clk_pin) else $error("trigger pin high with drive off");
    hold_one_a: assert property (ce && $past(ce) && !dual_ff
        && !$past(dual_ff) && datapath_run && $past(datapath_run)
        |-> sample_out == $past(sample_in)) else $error("one clock hold");
    hold_two_a: assert property (ce && dual_ff && $past(dual_ff)
        && datapath_run && $past(datapath_run) && $changed(sample_out)
        |=> $stable(sample_out)) else $error("two clock hold");
    dp_off_zero_a: assert property (ce && !datapath_run
        |=> sample_out == '0) else $error("sample out not cleared");
    sync_pass_a: assert property (ce && $past(ce) && proc_ff
        && $rose(sync_ref_in) |=> sync_ref_edge) else $error("edge lost");
    sync_block_a: assert property (ce && !proc_ff |=> !sync_ref_edge)
        else $error("edge passed while disabled");
    edge_once_a: assert property (ce && sync_ref_edge |=> !sync_ref_edge)
        else $error("edge pulse too long");
    sleep_copy_a: assert property ($stable(sleep_ff)
        |-> sync_ref_receiver_sleep == sleep_ff) else $error("sleep copy");
    tone_frozen_a: assert property (!ce
        |=> $stable({bank_sel_q, tone_sel_q})) else $error("tone moved");
    cover property ($rose(trig_clk_pin));
    cover property (sync_ref_edge);
    cover property (dual_ff && datapath_run && $changed(sample_out));
endmodule // tcsc_top_asserts

bind tcsc_top tcsc_top_asserts #(.SAMPLE_W(SAMPLE_W), .TONE_W(TONE_W)) u_chk
    (.clk, .rst, .ce, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
     .datapath_run, .osc_run, .sample_in, .sample_out, .trig_clk_pin,
     .tone_sel_in, .bank_sel_in, .tone_sel_q, .bank_sel_q, .sync_ref_in,
     .sync_ref_edge, .sync_ref_receiver_sleep);

// [testbench/tcsc_top_tb.sv]
// Self-checking bench for the trigger clock and sync configuration top
`timescale 1ns/1ps
module tcsc_top_tb
    import tcsc_pkg::*;
;
    logic clk = 0, rst = 1, ce = 1, reg_wr = 0, reg_rd = 0, trig_clk_pin;
    logic datapath_run = 0, osc_run = 0, bank_sel_in = 0, bank_sel_q;
    logic sync_ref_in = 0, sync_ref_edge, sync_ref_receiver_sleep;
    logic [9:0] reg_addr = '0;
    logic [15:0] reg_wdata = '0, reg_rdata;
    logic [11:0] sample_in = '0, sample_out, prev, last;
    logic [3:0] tone_sel_in = '0, tone_sel_q;
    int miscompares = 0, samples_checked = 0, seed = 57845, n, h, d, x, run;
    logic [9:0] ofs [6] = '{TCSC_OFS_DUAL_CLK, TCSC_OFS_TRIG_DIV,
        TCSC_OFS_TRIG_OUT, TCSC_OFS_SYNC_CTRL, TCSC_OFS_SAMPLED_IN, 10'h3ff};
    logic [15:0] rstv [6] = '{16'h0, 16'h0, 16'h0, 16'h2000, 16'h0, 16'h0};
    logic [15:0] msk [6] = '{16'hff, 16'hff, 16'hff, 16'he11f, 16'h0, 16'h0};

    tcsc_top uut (.clk, .rst, .ce, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
        .reg_rdata, .datapath_run, .osc_run, .sample_in, .sample_out,
        .trig_clk_pin, .tone_sel_in, .bank_sel_in, .tone_sel_q, .bank_sel_q,
        .sync_ref_in, .sync_ref_edge, .sync_ref_receiver_sleep);

    initial forever #5 clk = ~clk;
    // ----
    // Tasks
    // ----
    function automatic int half(input int dl, input int dv);
        return TCSC_PRE_DIV / 2 * (1 + dl) * (1 + dv);
    endfunction
    task automatic finish_test();
        if (miscompares == 0 && samples_checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        samples_checked++;
        if (g !== e)
        begin
            miscompares++;
            $display("[ERR] %0t got %h want %h", $time, g, e);
        end
    endtask
    task automatic wr(input logic [9:0] a, input logic [15:0] v);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= v;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [9:0] a, input logic [15:0] e);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 chk(reg_rdata, e);
    endtask
    task automatic wait_pin(input logic v, output int c);
        c = 0;
        while (trig_clk_pin !== v)
        begin
            @(posedge clk);
            #1 c++;
            if (c > 300)
            begin
                miscompares++;
                finish_test();
            end
        end
    endtask
    // ----
    // Main sequence
    // ----
    initial
    begin
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        for (int i = 0; i < 6; i++)
            rd(ofs[i], rstv[i]);
        repeat (4)
            for (int i = 0; i < 6; i++)
            begin
                x = $random(seed);
                if (i == 3)
                begin
                    wr(ofs[i], 16'h0);
                    x[13] = x[13] && !x[15];
                end
                wr(ofs[i], x[15:0]);
                rd(ofs[i], x[15:0] & msk[i]);
                if (i == 3)
                    chk(16'(sync_ref_receiver_sleep), 16'(x[13]));
            end
        for (int t = 0; t < 5; t++)
        begin
            d = (t == 0) ? 0 : $random(seed) & 3;
            n = (t == 0) ? 0 : $random(seed) & 1;
            h = half(n, d);
            wr(TCSC_OFS_DUAL_CLK, n[15:0]);
            wr(TCSC_OFS_TRIG_DIV, d[15:0]);
            wr(TCSC_OFS_TRIG_OUT, 16'h1);
            osc_run <= 1'b1;
            wait_pin(1'b1, x);
            wait_pin(1'b0, x);
            chk(x[15:0], h[15:0]);
            wait_pin(1'b1, x);
            chk(x[15:0], h[15:0]);
            x = $random(seed);
            @(posedge clk);
            {bank_sel_in, tone_sel_in} <= x[4:0];
            repeat (4 * h + 4) @(posedge clk);
            #1 chk({11'h0, bank_sel_q, tone_sel_q}, {11'h0, x[4:0]});
            rd(TCSC_OFS_SAMPLED_IN, {11'h0, x[4:0]});
            @(posedge clk);
            ce <= 1'b0;
            {bank_sel_in, tone_sel_in} <= ~x[4:0];
            repeat (4 * h + 4) @(posedge clk);
            #1 chk({11'h0, bank_sel_q, tone_sel_q}, {11'h0, x[4:0]});
            @(posedge clk);
            ce <= 1'b1;
            wr(TCSC_OFS_TRIG_OUT, 16'h0);
            repeat (3) @(posedge clk);
            n = 0;
            repeat (2 * h + 2)
            begin
                @(posedge clk);
                #1 n += (trig_clk_pin !== 1'b0);
            end
            chk(n[15:0], 16'h0);
            @(posedge clk);
            osc_run <= 1'b0;
        end
        for (int m = 0; m < 2; m++)
        begin
            @(posedge clk);
            datapath_run <= 1'b0;
            wr(TCSC_OFS_DUAL_CLK, m[15:0]);
            datapath_run <= 1'b1;
            run = 0;
            for (int i = 0; i < 40; i++)
            begin
                @(posedge clk);
                prev = sample_in;
                x = $random(seed);
                sample_in <= sample_in + {4'h0, x[7:0]} + 12'h1;
                #1;
                if (m == 0 && i > 2)
                    chk({4'h0, sample_out}, {4'h0, prev});
                if (m == 1 && sample_out !== last)
                begin
                    if (i > 6)
                    begin
                        chk(run[15:0], 16'h2);
                        chk({4'h0, sample_out}, {4'h0, prev});
                    end
                    run = 0;
                end
                run++;
                last = sample_out;
            end
        end
        @(posedge clk);
        datapath_run <= 1'b0;
        wr(TCSC_OFS_SYNC_CTRL, 16'h0);
        for (int p = 0; p < 2; p++)
        begin
            if (p == 1)
                wr(TCSC_OFS_SYNC_CTRL, 16'h8000);
            n = 0;
            for (int i = 0; i < 12; i++)
            begin
                @(posedge clk);
                sync_ref_in <= (12'h09a >> i) & 12'h1;
                #1 n += (sync_ref_edge === 1'b1);
            end
            chk(n[15:0], p ? 16'h3 : 16'h0);
        end
        finish_test();
    end
endmodule // tcsc_top_tb
